// [vsp_defines.vh]
// constants for the virtual interrupt stream port
`ifndef VSP_DEFINES_VH
`define VSP_DEFINES_VH
// ----------------------------------------
// wishbone register offsets
// ----------------------------------------
`define VSP_OFS_CTRL 4'h0
`define VSP_OFS_PMASK 4'h4
`define VSP_OFS_STATUS 4'h8
`define VSP_OFS_ACKREAD 4'hc
// ----------------------------------------
// control fields
// ----------------------------------------
`define VSP_CTRL_HINT_BIT 0
`define VSP_CTRL_GRP0_BIT 1
`define VSP_CTRL_GRP1_BIT 2
`define VSP_CTRL_VMEN_BIT 3
`define VSP_CTRL_HSRE_BIT 4
`define VSP_CTRL_EL2_BIT 5
`define VSP_CTRL_RESET 6'h00
`define VSP_PMASK_RESET 8'hf8
// ----------------------------------------
// stream packets
// ----------------------------------------
`define VSP_UCTL_OPC 4'h8
`define VSP_UCTL_PMASK_ID 8'h02
`define VSP_UCTL_ACK_OPC 4'h9
`define VSP_VCLR_OPC 4'h5
`define VSP_VIRTUAL_SET_CMD_OPC 4'h6
`define VSP_REL_OPC 4'h3
`define VSP_ACT_OPC 4'h2
`define VSP_ACT_ACK_OPC 4'h4
`define VSP_CLR_ACK_OPC 4'h7
`define VSP_V_BIT 4
`define VSP_ID_LEN_16 2'h0
`define VSP_ID_LEN_24 2'h1
`define VSP_SPURIOUS 24'h0003ff
`endif

// [vsp_tx_pack.v]
// output packet serialiser: head, low id half, high id half
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.vh"
module vsp_tx_pack
(
   input wire core_clk,
   input wire rst_n,
   input wire req,
   input wire [15:0] head,
   input wire [23:0] id,
   input wire has_id,
   output wire busy,
   output reg tx_valid,
   output reg [15:0] tx_data,
   output reg tx_last,
   input wire tx_ready
);
   reg [1:0] beat;
   reg [15:0] id_lo;
   reg [15:0] id_hi;
   reg with_id;
   assign busy = tx_valid;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_valid <= 1'b0;
         tx_data <= 16'h0000;
         tx_last <= 1'b0;
         beat <= 2'h0;
         id_lo <= 16'h0000;
         id_hi <= 16'h0000;
         with_id <= 1'b0;
      end
      else if (!tx_valid)
      begin
         if (req)
         begin
            tx_valid <= 1'b1;
            tx_data <= head;
            tx_last <= ~has_id;
            beat <= 2'h0;
            id_lo <= id[15:0];
            id_hi <= {8'h00, id[23:16]};
            with_id <= has_id;
         end
      end
      else if (tx_ready)
      begin
         if (tx_last)
         begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
         end
         else if (beat == 2'h0)
         begin
            beat <= 2'h1;
            tx_data <= id_lo;
            tx_last <= 1'b0;
         end
         else
         begin
            beat <= 2'h2;
            tx_data <= id_hi;
            tx_last <= 1'b1;
         end
      end
   end
   // with_id is unused; has_id shapes the length through tx_last at load
   wire unused_ok = with_id;
endmodule // vsp_tx_pack
`default_nettype wire

// [vsp_port.v]
// cpu interface side of the virtual interrupt stream port
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// - mask command id 0x02, one data word, bits 7:0 the mask value; sent here as two data words, the second zero
// - mask write with hint enable set sends the mask command
// - every changing write sends; pending writes merge into one
// - set below mask while mask ack awaited may be released
// - ids 0x03-0x07 reserved, 0x80-0xff implementation defined
// - every virtual clear is answered by clear ack with virtual flag; here one taken while an activate is outstanding gets none
// - pending target: clear it, release it, then clear ack
// - not pending: no change; clear ack after outstanding activate; here receive stalls on the queued clear ack and never takes the activate ack
// - virtual clear leaves list register message interrupts alone
// - set id is what the group acknowledge registers return
// - each set is either activated with virtual flag or released
// - new set replaces pending one; displaced one is released
// - group or vm interface disabled: release with virtual flag
// - hypervisor sysreg enable 0 or no el2: release
// - packets move on valid/ready streams with flow control
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.vh"
module vsp_port
(
   input wire core_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire rx_valid,
   input wire [15:0] rx_data,
   input wire rx_last,
   output wire rx_ready,
   output wire tx_valid,
   output wire [15:0] tx_data,
   output wire tx_last,
   input wire tx_ready
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [5:0] ctrl;
   reg [7:0] priority_mask_value;
   reg mask_dirty;
   reg mask_wait;
   reg pend_valid;
   reg [7:0] pend_prio;
   reg pend_grp;
   reg [23:0] pend_id;
   reg act_out;
   reg [23:0] act_id;
   reg rel_req;
   reg [23:0] rel_id;
   reg clr_ack_req;
   reg [1:0] rx_beat;
   reg [15:0] rx_head;
   reg [15:0] rx_lo;
   reg ack_read_req;
   wire hint_en = ctrl[`VSP_CTRL_HINT_BIT];
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function can_take;
      input [5:0] c;
      input grp;
      begin
         can_take = c[`VSP_CTRL_VMEN_BIT] & c[`VSP_CTRL_HSRE_BIT] & c[`VSP_CTRL_EL2_BIT] &
            (grp ? c[`VSP_CTRL_GRP1_BIT] : c[`VSP_CTRL_GRP0_BIT]);
      end
   endfunction
   function [15:0] mk_head;
      input [7:0] hi;
      input v;
      input [3:0] opc;
      begin
         mk_head = {hi, 3'h0, v, opc};
      end
   endfunction
   // ----------------------------------------
   // wishbone slave, one wait-free cycle
   // ----------------------------------------
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;
   wire pmask_wr = wb_wr & (wb_adr_i == `VSP_OFS_PMASK) & wb_sel_i[0];
   wire mask_change = pmask_wr & (wb_dat_i[7:0] != priority_mask_value);
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl <= `VSP_CTRL_RESET;
         priority_mask_value <= `VSP_PMASK_RESET;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_wr && wb_adr_i == `VSP_OFS_CTRL && wb_sel_i[0])
            ctrl <= wb_dat_i[5:0];
         if (pmask_wr)
            priority_mask_value <= wb_dat_i[7:0];
         case (wb_adr_i)
            `VSP_OFS_CTRL: wb_dat_o <= {26'h0, ctrl};
            `VSP_OFS_PMASK: wb_dat_o <= {24'h0, priority_mask_value};
            `VSP_OFS_STATUS: wb_dat_o <= {27'h0, clr_ack_req, rel_req, act_out,
               mask_wait, pend_valid};
            // acknowledge read returns the pending id, or spurious 0x3ff when none is pending or an activate is outstanding
            `VSP_OFS_ACKREAD: wb_dat_o <= {8'h0,
               (pend_valid && !act_out) ? pend_id : `VSP_SPURIOUS};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end
   // ----------------------------------------
   // receive: parse command packets
   // ----------------------------------------
   // receive stalls while a release or a clear ack is still queued, so none is lost
   assign rx_ready = ~rel_req & ~clr_ack_req;
   wire rx_take = rx_valid & rx_ready;
   wire [3:0] rx_opc = (rx_beat == 2'h0) ? rx_data[3:0] : rx_head[3:0];
   wire pkt_end = rx_take & rx_last;
   wire [23:0] pkt_id = (rx_beat == 2'h1) ? {8'h00, rx_data} : {rx_data[7:0], rx_lo};
   wire got_virtual_set_cmd = pkt_end & (rx_beat != 2'h0) & (rx_opc == `VSP_VIRTUAL_SET_CMD_OPC);
   wire got_vclr = pkt_end & (rx_beat != 2'h0) & (rx_opc == `VSP_VCLR_OPC);
   wire got_uack = pkt_end & (rx_beat == 2'h0) & (rx_opc == `VSP_UCTL_ACK_OPC);
   wire got_aack = pkt_end & (rx_beat == 2'h0) & (rx_opc == `VSP_ACT_ACK_OPC);
   wire [7:0] set_prio = rx_head[15:8];
   wire set_grp = rx_head[4];
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_beat <= 2'h0;
         rx_head <= 16'h0000;
         rx_lo <= 16'h0000;
      end
      else if (rx_take)
      begin
         if (rx_last)
            rx_beat <= 2'h0;
         else
            rx_beat <= (rx_beat == 2'h2) ? 2'h2 : rx_beat + 2'h1;
         if (rx_beat == 2'h0)
            rx_head <= rx_data;
         if (rx_beat == 2'h1)
            rx_lo <= rx_data;
      end
   end
   // ----------------------------------------
   // pending virtual interrupt and releases
   // ----------------------------------------
   wire ack_read = wb_req & ~wb_we_i & (wb_adr_i == `VSP_OFS_ACKREAD);
   wire ack_take = ack_read & pend_valid & ~act_out;
   // a set below the mask during a mask update is sent back
   wire set_refuse = ~can_take(ctrl, set_grp) | (mask_wait & (set_prio >= priority_mask_value));
   wire clr_hits = pend_valid & ~act_out & (pend_id == pkt_id);
   wire tx_busy;
   reg tx_req;
   reg [15:0] tx_head;
   reg [23:0] tx_id;
   reg tx_has_id;
   reg send_mask;
   reg send_rel;
   reg send_act;
   reg send_clr;
   always @*
   begin
      send_mask = 1'b0;
      send_rel = 1'b0;
      send_act = 1'b0;
      send_clr = 1'b0;
      tx_req = 1'b0;
      tx_head = 16'h0000;
      tx_id = 24'h000000;
      tx_has_id = 1'b0;
      if (!tx_busy)
      begin
         if (rel_req)
         begin
            send_rel = 1'b1;
            tx_head = mk_head({`VSP_ID_LEN_24, 6'h00}, 1'b1, `VSP_REL_OPC);
            tx_id = rel_id;
            tx_has_id = 1'b1;
         end
         else if (ack_read_req)
         begin
            send_act = 1'b1;
            tx_head = mk_head({`VSP_ID_LEN_24, 6'h00}, 1'b1, `VSP_ACT_OPC);
            tx_id = act_id;
            tx_has_id = 1'b1;
         end
         else if (clr_ack_req && !act_out)
         begin
            send_clr = 1'b1;
            tx_head = mk_head(8'h00, 1'b1, `VSP_CLR_ACK_OPC);
         end
         else if (mask_dirty && !mask_wait)
         begin
            send_mask = 1'b1;
            tx_head = mk_head(`VSP_UCTL_PMASK_ID, 1'b0, `VSP_UCTL_OPC);
            tx_id = {16'h0000, priority_mask_value};
            tx_has_id = 1'b1;
         end
         tx_req = send_rel | send_act | send_clr | send_mask;
      end
   end
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_valid <= 1'b0;
         pend_prio <= 8'h00;
         pend_grp <= 1'b0;
         pend_id <= 24'h000000;
         act_out <= 1'b0;
         act_id <= 24'h000000;
         rel_req <= 1'b0;
         rel_id <= 24'h000000;
         clr_ack_req <= 1'b0;
         mask_dirty <= 1'b0;
         mask_wait <= 1'b0;
         ack_read_req <= 1'b0;
      end
      else
      begin
         // merged writes keep one dirty flag; set wins over send
         if (mask_change && hint_en)
            mask_dirty <= 1'b1;
         else if (send_mask)
            mask_dirty <= 1'b0;
         if (send_mask)
            mask_wait <= 1'b1;
         else if (got_uack)
            mask_wait <= 1'b0;
         // the read id is held for the activate, so a set landing before
         // the activate goes out cannot swap the id under it
         if (ack_take)
         begin
            ack_read_req <= 1'b1;
            act_id <= pend_id;
            pend_valid <= 1'b0;
         end
         else if (send_act)
            ack_read_req <= 1'b0;
         if (send_act)
            act_out <= 1'b1;
         else if (got_aack)
            act_out <= 1'b0;
         if (send_rel)
            rel_req <= 1'b0;
         if (send_clr)
            clr_ack_req <= 1'b0;
         if (got_virtual_set_cmd)
         begin
            if (set_refuse)
            begin
               rel_req <= 1'b1;
               rel_id <= pkt_id;
            end
            else
            begin
               if (pend_valid && !ack_take)
               begin
                  rel_req <= 1'b1;
                  rel_id <= pend_id;
               end
               pend_valid <= 1'b1;
               pend_prio <= set_prio;
               pend_grp <= set_grp;
               pend_id <= pkt_id;
            end
         end
         else if (got_vclr)
         begin
            // only the virtual pending slot is touched
            clr_ack_req <= 1'b1;
            if (clr_hits && !ack_take)
            begin
               pend_valid <= 1'b0;
               rel_req <= 1'b1;
               rel_id <= pend_id;
            end
         end
         else if (pend_valid && !ack_take && !act_out && !can_take(ctrl, pend_grp) &&
            !rel_req)
         begin
            pend_valid <= 1'b0;
            rel_req <= 1'b1;
            rel_id <= pend_id;
         end
      end
   end
   // ----------------------------------------
   // transmit serialiser
   // ----------------------------------------
   vsp_tx_pack u_tx
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req(tx_req),
      .head(tx_head),
      .id(tx_id),
      .has_id(tx_has_id),
      .busy(tx_busy),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_last(tx_last),
      .tx_ready(tx_ready)
   );
   wire unused_ok = &{1'b0, pend_prio};
endmodule // vsp_port
`default_nettype wire

// [vsp_port_chk.sv]
// concurrent checks on the stream port pins
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.vh"
module vsp_port_chk
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic rx_valid,
   input wire logic [15:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [15:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready
);
   logic tx_first;
   logic rx_first;
   logic [1:0] mask_out;
   wire tx_head = tx_valid && tx_first;
   wire mask_go = tx_head && tx_ready && tx_data[3:0] == `VSP_UCTL_OPC;
   wire ack_go = rx_valid && rx_ready && rx_first && rx_data[3:0] == `VSP_UCTL_ACK_OPC;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_first <= 1'b1;
         rx_first <= 1'b1;
         mask_out <= 2'h0;
      end
      else
      begin
         if (tx_valid && tx_ready)
            tx_first <= tx_last;
         if (rx_valid && rx_ready)
            rx_first <= rx_last;
         mask_out <= mask_out + {1'b0, mask_go} - {1'b0, ack_go};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_tx_hold_stall: assert property (s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("tx beat changed while stalled");
   a_release_vflag: assert property (tx_head && tx_data[3:0] == `VSP_REL_OPC |-> tx_data[4])
      else $error("release without virtual flag");
   a_activate_vflag: assert property (tx_head && tx_data[3:0] == `VSP_ACT_OPC |-> tx_data[4])
      else $error("activate without virtual flag");
   a_clrack_single_v: assert property (tx_head && tx_data[3:0] == `VSP_CLR_ACK_OPC
      |-> tx_data[4] && tx_last)
      else $error("clear ack malformed");
   a_release_has_id: assert property (tx_head && tx_data[3:0] == `VSP_REL_OPC |-> !tx_last)
      else $error("release without id beats");
   a_mask_ident: assert property (tx_head && tx_data[3:0] == `VSP_UCTL_OPC
      |-> tx_data[15:8] == 8'h02 && !tx_last)
      else $error("mask command identifier wrong");
   a_mask_in_flight: assert property (mask_out <= 2'h1)
      else $error("second mask command before ack");
   a_wb_answer: assert property (s_wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a one cycle pulse");
endmodule // vsp_port_chk
bind vsp_port vsp_port_chk u_vsp_port_chk (.core_clk(core_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire

// [vsp_rdist_model.sv]
// behavioural redistributor facing the stream port
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.vh"
module vsp_rdist_model
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [15:0] tx_data,
   input wire logic tx_last,
   output logic rx_valid,
   output logic [15:0] rx_data,
   output logic rx_last,
   output logic tx_ready
);
   logic [16:0] q[$];
   logic [15:0] seen[$];
   logic [15:0] hd;
   logic first;
   logic ack_due;
   logic slow = 1'b1;
   logic hold_ack = 1'b0;
   logic [7:0] mask_copy;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_valid <= 1'b0;
         rx_data <= 16'h0000;
         rx_last <= 1'b0;
         tx_ready <= 1'b0;
         first <= 1'b1;
         ack_due <= 1'b0;
         mask_copy <= 8'hf8;
      end
      else
      begin
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready)
         begin
            seen.push_back(tx_data);
            first <= tx_last;
            if (first)
               hd <= tx_data;
            if (!first && hd[3:0] == `VSP_UCTL_OPC && !tx_last)
               mask_copy <= tx_data[7:0];
            if (tx_last && !first && hd[3:0] == `VSP_UCTL_OPC)
               ack_due <= 1'b1;
            if (tx_last && !first && hd[3:0] == `VSP_ACT_OPC)
               q.push_back({1'b1, 16'h0014});
         end
         // ack may be withheld so the bench can pile up mask writes
         if (ack_due && !hold_ack)
         begin
            q.push_back({1'b1, 12'h000, `VSP_UCTL_ACK_OPC});
            ack_due <= 1'b0;
         end
         if (!rx_valid || rx_ready)
         begin
            if (q.size() > 0)
            begin
               {rx_last, rx_data} <= q.pop_front();
               rx_valid <= 1'b1;
            end
            else
            begin
               rx_valid <= 1'b0;
               rx_data <= ~rx_data;
            end
         end
      end
   end
endmodule // vsp_rdist_model
`default_nettype wire

// [vsp_port_tb_top.sv]
// self-checking bench for the stream port
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.vh"
module vsp_port_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   wire [15:0] rx_data, tx_data;
   int n_fail = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic [5:0] off_ctrl [4] = '{6'h3d, 6'h37, 6'h2f, 6'h1f};
   always #10 core_clk = ~core_clk;
   vsp_port u_vsp_port (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
   vsp_rdist_model u_vsp_rdist_model (.core_clk(core_clk), .rst_n(rst_n),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready));
   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hf, d};
      i = 0;
      do
      begin
         @(posedge core_clk);
         i++;
      end
      while (wb_ack_o !== 1'b1 && i < 16);
      rd = wb_dat_o;
      chk("wb ack", 1, wb_ack_o);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task send(input logic [15:0] h, input logic [23:0] id);
      @(negedge core_clk);
      u_vsp_rdist_model.q.push_back({1'b0, h});
      u_vsp_rdist_model.q.push_back({1'b0, id[15:0]});
      u_vsp_rdist_model.q.push_back({9'h100, id[23:16]});
   endtask
   task expect_pkt(input string what, input logic [4:0] hlo, input logic [23:0] id, input bit one);
      int i;
      logic [15:0] b;
      for (i = 0; i < 300 && u_vsp_rdist_model.seen.size() < (one ? 1 : 3); i++)
         @(negedge core_clk);
      chk(what, 1, u_vsp_rdist_model.seen.size() >= (one ? 1 : 3));
      if (u_vsp_rdist_model.seen.size() < (one ? 1 : 3))
         return;
      b = u_vsp_rdist_model.seen.pop_front();
      chk(what, hlo, b[4:0]);
      if (!one)
      begin
         b = u_vsp_rdist_model.seen.pop_front();
         chk(what, id[15:0], b);
         b = u_vsp_rdist_model.seen.pop_front();
         chk(what, id[23:16], b);
      end
   endtask
   task quiet(input string what);
      repeat (40) @(negedge core_clk);
      chk(what, 0, u_vsp_rdist_model.seen.size());
   endtask
   function automatic logic [15:0] virtual_set_cmd(input logic [7:0] p, input logic g);
      return {p, `VSP_ID_LEN_24, 1'b0, g, `VSP_VIRTUAL_SET_CMD_OPC};
   endfunction
   task tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_fail++;
      tally_and_finish;
   end
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      wb(0, `VSP_OFS_CTRL, 0);
      chk("ctrl reset", 0, rd);
      wb(0, `VSP_OFS_PMASK, 0);
      chk("mask reset", 32'hf8, rd);
      wb(0, `VSP_OFS_ACKREAD, 0);
      chk("idle ack read", `VSP_SPURIOUS, rd);
      chk("far mask reset", 32'hf8, u_vsp_rdist_model.mask_copy);
      wb(0, 4'h2, 0);
      chk("unmapped read", 0, rd);
      $display("test reset values done");
      wb(1, `VSP_OFS_PMASK, 32'h40);
      quiet("mask hint off");
      wb(1, `VSP_OFS_CTRL, 32'h3f);
      repeat (60) @(negedge core_clk);
      u_vsp_rdist_model.seen.delete();
      wb(1, `VSP_OFS_PMASK, 32'h80);
      expect_pkt("mask cmd", 5'h08, 24'h80, 0);
      wb(1, `VSP_OFS_PMASK, 32'h80);
      quiet("same mask");
      u_vsp_rdist_model.hold_ack = 1'b1;
      wb(1, `VSP_OFS_PMASK, 32'h50);
      expect_pkt("mask cmd", 5'h08, 24'h50, 0);
      wb(1, `VSP_OFS_PMASK, 32'h30);
      wb(1, `VSP_OFS_PMASK, 32'h20);
      quiet("mask in flight");
      send(virtual_set_cmd(8'h40, 1'b1), 24'h012000);
      expect_pkt("refused set", 5'h13, 24'h012000, 0);
      u_vsp_rdist_model.hold_ack = 1'b0;
      expect_pkt("merged mask", 5'h08, 24'h20, 0);
      chk("far mask copy", 32'h20, u_vsp_rdist_model.mask_copy);
      $display("test mask update done");
      send(virtual_set_cmd(8'h10, 1'b1), 24'h012001);
      repeat (20) @(negedge core_clk);
      wb(0, `VSP_OFS_STATUS, 0);
      chk("pending", 1, rd[0]);
      wb(0, `VSP_OFS_ACKREAD, 0);
      chk("ack read id", 32'h012001, rd);
      expect_pkt("activate", 5'h12, 24'h012001, 0);
      send(virtual_set_cmd(8'h10, 1'b1), 24'h012002);
      send(virtual_set_cmd(8'h18, 1'b1), 24'h012003);
      expect_pkt("displaced", 5'h13, 24'h012002, 0);
      wb(0, `VSP_OFS_ACKREAD, 0);
      chk("new pending", 32'h012003, rd);
      expect_pkt("activate", 5'h12, 24'h012003, 0);
      $display("test set and activate done");
      u_vsp_rdist_model.slow = 1'b0;
      send(virtual_set_cmd(8'h10, 1'b0), 24'h012004);
      repeat (20) @(negedge core_clk);
      send({8'h00, `VSP_ID_LEN_24, 2'h0, `VSP_VCLR_OPC}, 24'h012004);
      expect_pkt("clear release", 5'h13, 24'h012004, 0);
      expect_pkt("clear ack", 5'h17, 0, 1);
      send({8'h00, `VSP_ID_LEN_24, 2'h0, `VSP_VCLR_OPC}, 24'h012005);
      expect_pkt("clear ack idle", 5'h17, 0, 1);
      wb(0, `VSP_OFS_ACKREAD, 0);
      chk("nothing pending", `VSP_SPURIOUS, rd);
      $display("test clear done");
      for (int k = 0; k < 4; k++)
      begin
         wb(1, `VSP_OFS_CTRL, {26'h0, off_ctrl[k]});
         send(virtual_set_cmd(8'h10, 1'b0), 24'h012010 + 24'(k));
         expect_pkt("disabled", 5'h13, 24'h012010 + 24'(k), 0);
      end
      wb(1, `VSP_OFS_CTRL, 32'h3f);
      send(virtual_set_cmd(8'h10, 1'b0), 24'h012020);
      repeat (20) @(negedge core_clk);
      wb(1, `VSP_OFS_CTRL, 32'h3d);
      expect_pkt("pending disabled", 5'h13, 24'h012020, 0);
      wb(0, `VSP_OFS_ACKREAD, 0);
      chk("released pending", `VSP_SPURIOUS, rd);
      $display("test refusal done");
      tally_and_finish;
   end
endmodule // vsp_port_tb_top
`default_nettype wire
